// >>> design/spfp_defs.vh
`ifndef SPFP_DEFS_VH
`define SPFP_DEFS_VH

// ==========================================================================
// register indices; byte address is four times the index
`define SPFP_IDX_PORTA_DATA 6'h00
`define SPFP_IDX_PORTB_DATA 6'h01
`define SPFP_IDX_DIRA 6'h04
`define SPFP_IDX_DIRB 6'h05
`define SPFP_IDX_PULLA 6'h0B
`define SPFP_IDX_PULLB 6'h0C
`define SPFP_IDX_MUXCTL 6'h10
`define SPFP_IDX_OWNSTAT 6'h11

// ==========================================================================
// register selects produced by the address decoder
`define SPFP_SEL_NONE 4'h0
`define SPFP_SEL_PORTA 4'h1
`define SPFP_SEL_PORTB 4'h2
`define SPFP_SEL_DIRA 4'h3
`define SPFP_SEL_DIRB 4'h4
`define SPFP_SEL_PULLA 4'h5
`define SPFP_SEL_PULLB 4'h6
`define SPFP_SEL_MUXCTL 4'h7
`define SPFP_SEL_OWNSTAT 4'h8

// ==========================================================================
// field layout and reset values
`define SPFP_ADDR_W 8
`define SPFP_PORTA_MASK 6'h3F
`define SPFP_DIRA_MASK 6'h3B
`define SPFP_OSC_OUT_EN_BIT 7
`define SPFP_MUX_EN_BIT 0
`define SPFP_DIR_RST 8'h00
`define SPFP_PULL_RST 8'h00
`define SPFP_DIRA_RST 6'h00
`define SPFP_PULLA_RST 6'h00
`define SPFP_MUXCTL_RST 1'h0
`define SPFP_RESP_OKAY 2'h0
`define SPFP_RESP_SLVERR 2'h2

// ==========================================================================
// pad owner codes, highest level wins
`define SPFP_OWN_PORT 2'h0
`define SPFP_OWN_LVL1 2'h1
`define SPFP_OWN_LVL2 2'h2
`define SPFP_OWN_LVL3 2'h3
`define SPFP_STRAP_WAIT 3'h5

`endif

// >>> design/spfp_sync3.v
`timescale 1ns/1ps

module spfp_sync3 #(
  parameter W = 15
) (
  input wire sys_clk,
  input wire arst_n,
  input wire [W-1:0] asyncIn,
  output reg [W-1:0] syncOut
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;

  // ========================================================================
  // three flops and an output flop; a bit changes only once stages two and three agree
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= {W{1'b0}};
      stage2 <= {W{1'b0}};
      stage3 <= {W{1'b0}};
      syncOut <= {W{1'b0}};
    end
    else
    begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
      syncOut <= (stage2 & stage3) | (syncOut & (stage2 ^ stage3));
    end
  end

endmodule

// >>> design/spfp_pad_resolve.v
`timescale 1ns/1ps
`include "spfp_defs.vh"

module spfp_pad_resolve (
  input wire [3:0] claim,
  input wire [3:0] drvOe,
  input wire [3:0] drvOut,
  input wire [3:0] drvPull,
  output reg [1:0] owner,
  output reg padOe,
  output reg padOut,
  output reg padPull
);

  // ========================================================================
  // fixed priority: level 3 highest, level 0 is the port bit itself
  always @*
  begin
    if (claim[3])
      owner = `SPFP_OWN_LVL3;
    else if (claim[2])
      owner = `SPFP_OWN_LVL2;
    else if (claim[1])
      owner = `SPFP_OWN_LVL1;
    else
      owner = `SPFP_OWN_PORT;
    // only the owner steers driver and pull-up
    padOe = drvOe[owner]; // [R15]
    padOut = drvOut[owner]; // [R15]
    padPull = drvPull[owner]; // [R15]
  end

endmodule

// >>> design/spfp_pin_mux.v
// Overview of operation
// [R01] after reset every pad is a port input
// [R02] pad A0: analog0, timer0, keypad0, port
// [R03] pad A1: analog1, timer1, keypad1, port
// [R04] pad A2: interrupt, timer clock, keypad2, port
// [R05] pad A3: reset input, keypad3, port
// [R06] pad A4: oscillator out, analog2, keypad4, port
// [R07] pad A5: oscillator in, analog3, keypad5, port
// [R08] pad B0: analog4 when selected, else port
// [R09] pad B1: analog5 when selected, else port
// [R10] analog selection never overrides other functions
// [R11] software keeps analog pads input, others off
// [R12] port B pads absent on small package
// [R13] software terminates unbonded bits: output or pull-up
// [R14] oscillator out: crystal, or enable bit set
// [R15] owner alone drives pad and pull-up
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "spfp_defs.vh"

module spfp_pin_mux (
  input wire sys_clk,
  input wire arst_n,
  input wire [`SPFP_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`SPFP_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire pkgWide,
  input wire [5:0] analogChannelSel,
  input wire [1:0] timerChannelEn,
  input wire [1:0] timerChannelOe,
  input wire [1:0] timerChannelOut,
  input wire timerClockEn,
  input wire extIrqEn,
  input wire extIrqPullEn,
  input wire extResetEn,
  input wire [5:0] keypadEn,
  input wire oscXtalMode,
  input wire oscOutReq,
  input wire oscOutClk,
  input wire oscInEn,
  output reg [1:0] timerChannelIn,
  output reg timerClockIn,
  output reg extIrqIn_n,
  output reg extResetIn_n,
  output reg [5:0] keypadIn,
  output reg oscillatorIn,
  output reg [5:0] analogConnect,
  input wire [13:0] padIn,
  output reg [13:0] padOut,
  output reg [13:0] padOe,
  output reg [13:0] padPullup
);

  // ========================================================================
  // helpers
  function [3:0] regSel;
    input [`SPFP_ADDR_W-1:0] addr;
    begin
      regSel = `SPFP_SEL_NONE;
      if (addr[1:0] == 2'b00)
      begin
        case (addr[7:2])
          `SPFP_IDX_PORTA_DATA: regSel = `SPFP_SEL_PORTA;
          `SPFP_IDX_PORTB_DATA: regSel = `SPFP_SEL_PORTB;
          `SPFP_IDX_DIRA: regSel = `SPFP_SEL_DIRA;
          `SPFP_IDX_DIRB: regSel = `SPFP_SEL_DIRB;
          `SPFP_IDX_PULLA: regSel = `SPFP_SEL_PULLA;
          `SPFP_IDX_PULLB: regSel = `SPFP_SEL_PULLB;
          `SPFP_IDX_MUXCTL: regSel = `SPFP_SEL_MUXCTL;
          `SPFP_IDX_OWNSTAT: regSel = `SPFP_SEL_OWNSTAT;
          default: regSel = `SPFP_SEL_NONE;
        endcase
      end
    end
  endfunction

  // ========================================================================
  // state
  reg [5:0] portALatch;
  reg [7:0] portBLatch;
  reg [5:0] dirA;
  reg [7:0] dirB;
  reg [5:0] pullA;
  reg oscOutPadEnable;
  reg [7:0] pullB;
  reg muxEnable;
  reg pkgWideReg;
  reg [2:0] strapCnt;
  reg [15:0] ownerStat;
  reg awHeld;
  reg wHeld;
  reg [`SPFP_ADDR_W-1:0] awAddrHeld;
  reg [7:0] wDataHeld;
  reg wLane0Held;

  wire [14:0] syncIn;
  wire [13:0] padLvl;
  wire pkgLvl;
  wire [55:0] claim;
  wire [55:0] drvOe;
  wire [55:0] drvOut;
  wire [55:0] drvPull;
  wire [27:0] owner;
  wire [13:0] resOe;
  wire [13:0] resOut;
  wire [13:0] resPull;
  wire [13:0] portOe;
  wire [13:0] portPull;
  wire [13:0] portOutV;
  wire [3:0] claimMask;
  wire oscOutActive;
  wire doWrite;
  wire next_awHeld;
  wire next_wHeld;
  wire next_bvalid;
  wire next_rvalid;
  wire [3:0] wrSel;
  wire [7:0] portARead;
  wire [7:0] portBRead;
  reg [31:0] readData;

  // ========================================================================
  // pad input synchroniser, strap rides along
  spfp_sync3 #(
    .W(15)
  ) uSync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .asyncIn({pkgWide, padIn}),
    .syncOut(syncIn)
  );

  assign padLvl = syncIn[13:0];
  assign pkgLvl = syncIn[14];

  // ========================================================================
  // claims per pad, {level3, level2, level1, port}
  // peripheral claims stay masked until software arms the mux
  assign claimMask = {muxEnable, muxEnable, muxEnable, 1'b1}; // [R01]
  assign portOe = {dirB, dirA};
  assign portOutV = {portBLatch, portALatch};
  assign portPull = {pullB, pullA} & ~portOe;
  assign oscOutActive = oscXtalMode | (oscOutReq & oscOutPadEnable); // [R14]

  // analog selection takes no level; digital owners keep the pad
  assign claim[3:0] = {1'b0, timerChannelEn[0], keypadEn[0], 1'b1} & claimMask; // [R02] [R10]
  assign drvOe[3:0] = {1'b0, timerChannelOe[0], 1'b0, portOe[0]};
  assign drvOut[3:0] = {1'b0, timerChannelOut[0], 1'b0, portOutV[0]};
  assign drvPull[3:0] = {1'b0, pullA[0] & ~timerChannelOe[0], pullA[0], portPull[0]};

  assign claim[7:4] = {1'b0, timerChannelEn[1], keypadEn[1], 1'b1} & claimMask; // [R03] [R10]
  assign drvOe[7:4] = {1'b0, timerChannelOe[1], 1'b0, portOe[1]};
  assign drvOut[7:4] = {1'b0, timerChannelOut[1], 1'b0, portOutV[1]};
  assign drvPull[7:4] = {1'b0, pullA[1] & ~timerChannelOe[1], pullA[1], portPull[1]};

  // input-only pad: direction bit is not writable
  assign claim[11:8] = {extIrqEn, timerClockEn, keypadEn[2], 1'b1} & claimMask; // [R04]
  assign drvOe[11:8] = 4'h0;
  assign drvOut[11:8] = 4'h0;
  assign drvPull[11:8] = {extIrqPullEn, pullA[2], pullA[2], pullA[2]};

  // reset input carries a fixed internal pull-up
  assign claim[15:12] = {extResetEn, 1'b0, keypadEn[3], 1'b1} & claimMask; // [R05]
  assign drvOe[15:12] = {3'h0, portOe[3]};
  assign drvOut[15:12] = {3'h0, portOutV[3]};
  assign drvPull[15:12] = {1'b1, 1'b0, pullA[3], portPull[3]};

  assign claim[19:16] = {oscOutActive, 1'b0, keypadEn[4], 1'b1} & claimMask; // [R06] [R10]
  assign drvOe[19:16] = {1'b1, 2'h0, portOe[4]};
  assign drvOut[19:16] = {oscOutClk, 2'h0, portOutV[4]};
  assign drvPull[19:16] = {2'h0, pullA[4], portPull[4]};

  assign claim[23:20] = {oscInEn, 1'b0, keypadEn[5], 1'b1} & claimMask; // [R07] [R10]
  assign drvOe[23:20] = {3'h0, portOe[5]};
  assign drvOut[23:20] = {3'h0, portOutV[5]};
  assign drvPull[23:20] = {2'h0, pullA[5], portPull[5]};

  genvar gi;
  generate
    // port B pads: only the port bit competes for the digital driver
    for (gi = 6; gi < 14; gi = gi + 1)
    begin : gPortB
      assign claim[4*gi+3:4*gi] = 4'h1; // [R08] [R09]
      assign drvOe[4*gi+3:4*gi] = {3'h0, portOe[gi]};
      assign drvOut[4*gi+3:4*gi] = {3'h0, portOutV[gi]};
      assign drvPull[4*gi+3:4*gi] = {3'h0, portPull[gi]};
    end
    for (gi = 0; gi < 14; gi = gi + 1)
    begin : gResolve
      spfp_pad_resolve uRes (
        .claim(claim[4*gi+3:4*gi]),
        .drvOe(drvOe[4*gi+3:4*gi]),
        .drvOut(drvOut[4*gi+3:4*gi]),
        .drvPull(drvPull[4*gi+3:4*gi]),
        .owner(owner[2*gi+1:2*gi]),
        .padOe(resOe[gi]),
        .padOut(resOut[gi]),
        .padPull(resPull[gi])
      );
    end
  endgenerate

  // ========================================================================
  // pad drivers and peripheral inputs, all registered
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      padOe <= 14'h0000; // [R01]
      padOut <= 14'h0000;
      padPullup <= 14'h0000;
      ownerStat <= 16'h0000;
      timerChannelIn <= 2'h0;
      timerClockIn <= 1'b0;
      extIrqIn_n <= 1'b1;
      extResetIn_n <= 1'b1;
      keypadIn <= 6'h00;
      oscillatorIn <= 1'b0;
      analogConnect <= 6'h00;
    end
    else
    begin
      padOe[5:0] <= resOe[5:0];
      padOut[5:0] <= resOut[5:0];
      padPullup[5:0] <= resPull[5:0];
      // no bond wire on the small package: never drive or pull
      padOe[13:6] <= pkgWideReg ? resOe[13:6] : 8'h00; // [R12]
      padOut[13:6] <= pkgWideReg ? resOut[13:6] : 8'h00; // [R12]
      padPullup[13:6] <= pkgWideReg ? resPull[13:6] : 8'h00; // [R12]
      ownerStat <= owner[15:0];
      // switch closes on selection, for analog4 and analog5 only on the wide package; ignoring other users is up to software
      analogConnect <= analogChannelSel & {pkgWideReg, pkgWideReg, 4'hF}; // [R10] [R11]
      timerChannelIn[0] <= (owner[1:0] == `SPFP_OWN_LVL2) & padLvl[0];
      timerChannelIn[1] <= (owner[3:2] == `SPFP_OWN_LVL2) & padLvl[1];
      extIrqIn_n <= (owner[5:4] == `SPFP_OWN_LVL3) ? padLvl[2] : 1'b1; // [R04]
      timerClockIn <= (owner[5:4] == `SPFP_OWN_LVL2) & padLvl[2]; // [R04]
      extResetIn_n <= (owner[7:6] == `SPFP_OWN_LVL3) ? padLvl[3] : 1'b1; // [R05]
      oscillatorIn <= (owner[11:10] == `SPFP_OWN_LVL3) & padLvl[5]; // [R07]
      keypadIn[0] <= (owner[1:0] == `SPFP_OWN_LVL1) & padLvl[0];
      keypadIn[1] <= (owner[3:2] == `SPFP_OWN_LVL1) & padLvl[1];
      keypadIn[2] <= (owner[5:4] == `SPFP_OWN_LVL1) & padLvl[2];
      keypadIn[3] <= (owner[7:6] == `SPFP_OWN_LVL1) & padLvl[3];
      keypadIn[4] <= (owner[9:8] == `SPFP_OWN_LVL1) & padLvl[4];
      keypadIn[5] <= (owner[11:10] == `SPFP_OWN_LVL1) & padLvl[5];
    end
  end

  // ========================================================================
  // package strap, caught once the synchroniser has settled
  // the synchronised strap is first valid at the fourth edge, so wait for the fifth
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strapCnt <= 3'h0;
      pkgWideReg <= 1'b0;
    end
    else if (strapCnt != `SPFP_STRAP_WAIT)
    begin
      strapCnt <= strapCnt + 3'h1;
      if (strapCnt == `SPFP_STRAP_WAIT - 3'h1)
        pkgWideReg <= pkgLvl;
    end
  end

  // ========================================================================
  // bus write path: address and data taken in either order
  assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
  assign next_awHeld = awHeld ? ~doWrite : (s_axi_awvalid & s_axi_awready);
  assign next_wHeld = wHeld ? ~doWrite : (s_axi_wvalid & s_axi_wready);
  assign next_bvalid = doWrite | (s_axi_bvalid & ~s_axi_bready);
  assign wrSel = regSel(awAddrHeld);

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrHeld <= {`SPFP_ADDR_W{1'b0}};
      wDataHeld <= 8'h00;
      wLane0Held <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SPFP_RESP_OKAY;
      portALatch <= 6'h00;
      portBLatch <= 8'h00;
      dirA <= `SPFP_DIRA_RST; // [R01]
      dirB <= `SPFP_DIR_RST; // [R01]
      pullA <= `SPFP_PULLA_RST;
      oscOutPadEnable <= 1'b0;
      pullB <= `SPFP_PULL_RST;
      muxEnable <= `SPFP_MUXCTL_RST; // [R01]
    end
    else
    begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      s_axi_bvalid <= next_bvalid;
      s_axi_awready <= ~next_awHeld & ~next_bvalid;
      s_axi_wready <= ~next_wHeld & ~next_bvalid;
      if (s_axi_awvalid & s_axi_awready)
        awAddrHeld <= s_axi_awaddr;
      if (s_axi_wvalid & s_axi_wready)
      begin
        wDataHeld <= s_axi_wdata[7:0];
        wLane0Held <= s_axi_wstrb[0];
      end
      if (doWrite)
      begin
        s_axi_bresp <= (wrSel == `SPFP_SEL_NONE) ? `SPFP_RESP_SLVERR : `SPFP_RESP_OKAY;
        if (wLane0Held)
        begin
          case (wrSel)
            `SPFP_SEL_PORTA: portALatch <= wDataHeld[5:0] & `SPFP_PORTA_MASK;
            `SPFP_SEL_PORTB: portBLatch <= wDataHeld;
            `SPFP_SEL_DIRA: dirA <= wDataHeld[5:0] & `SPFP_DIRA_MASK;
            `SPFP_SEL_DIRB: dirB <= wDataHeld;
            `SPFP_SEL_PULLA:
            begin
              pullA <= wDataHeld[5:0];
              oscOutPadEnable <= wDataHeld[`SPFP_OSC_OUT_EN_BIT];
            end
            `SPFP_SEL_PULLB: pullB <= wDataHeld;
            `SPFP_SEL_MUXCTL: muxEnable <= wDataHeld[`SPFP_MUX_EN_BIT];
            default: muxEnable <= muxEnable;
          endcase
        end
      end
    end
  end

  // ========================================================================
  // bus read path
  // inputs read the synchronised pad, outputs read back the latch
  assign portARead = {2'h0, (dirA & portALatch) | (~dirA & padLvl[5:0])};
  // unbonded input bits read 1 under pull-up, 0 otherwise, as a terminated pin would
  assign portBRead = (dirB & portBLatch) |
                     (~dirB & (pkgWideReg ? padLvl[13:6] : pullB)); // [R13]

  always @*
  begin
    readData = 32'h00000000;
    case (regSel(s_axi_araddr))
      `SPFP_SEL_PORTA: readData[7:0] = portARead;
      `SPFP_SEL_PORTB: readData[7:0] = portBRead;
      `SPFP_SEL_DIRA: readData[5:0] = dirA;
      `SPFP_SEL_DIRB: readData[7:0] = dirB;
      `SPFP_SEL_PULLA: readData[7:0] = {oscOutPadEnable, 1'b0, pullA};
      `SPFP_SEL_PULLB: readData[7:0] = pullB;
      `SPFP_SEL_MUXCTL: readData[`SPFP_MUX_EN_BIT] = muxEnable;
      `SPFP_SEL_OWNSTAT: readData[15:0] = ownerStat;
      default: readData = 32'h00000000;
    endcase
  end

  assign next_rvalid = (s_axi_arvalid & s_axi_arready) | (s_axi_rvalid & ~s_axi_rready);

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SPFP_RESP_OKAY;
    end
    else
    begin
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rdata <= readData;
        s_axi_rresp <= (regSel(s_axi_araddr) == `SPFP_SEL_NONE) ?
                       `SPFP_RESP_SLVERR : `SPFP_RESP_OKAY;
      end
    end
  end

endmodule

// >>> tb/spfp_checker.sv
`timescale 1ns/1ps

// ==========================================================================
// port-level checks on the pin mux
module spfp_checker (
  input wire sys_clk,
  input wire arst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire pkgWide,
  input wire [5:0] analogChannelSel,
  input wire extIrqEn,
  input wire extResetEn,
  input wire extIrqIn_n,
  input wire extResetIn_n,
  input wire [5:0] analogConnect,
  input wire [13:0] padOe,
  input wire [13:0] padPullup
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  a_reset_pads_idle: assert property ($rose(arst_n) |-> padOe == 14'h0000 && padPullup == 14'h0000)
    else $error("pads not idle after reset");
  a_irq_input_only: assert property (!padOe[2])
    else $error("input-only pad driven");
  a_irq_idle_high: assert property ((!extIrqEn) [*4] |-> extIrqIn_n)
    else $error("interrupt input active while function off");
  a_reset_idle_high: assert property ((!extResetEn) [*4] |-> extResetIn_n)
    else $error("reset input active while function off");
  a_analog_follow: assert property ($past(arst_n) && $stable(analogChannelSel)
    |-> analogConnect[3:0] == analogChannelSel[3:0])
    else $error("analog switch does not follow selection");
  a_small_no_analog: assert property ((!pkgWide) [*6] |-> analogConnect[5:4] == 2'h0)
    else $error("unbonded analog channel connected");
  a_small_no_drive: assert property ((!pkgWide) [*6]
    |-> padOe[13:6] == 8'h00 && padPullup[13:6] == 8'h00)
    else $error("unbonded port pad driven");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_irq_active: cover property (!extIrqIn_n);
  c_wide_analog: cover property (analogConnect[5]);
endmodule

bind spfp_pin_mux spfp_checker chk (.sys_clk, .arst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pkgWide, .analogChannelSel,
  .extIrqEn, .extResetEn, .extIrqIn_n, .extResetIn_n, .analogConnect, .padOe, .padPullup);

// >>> tb/spfp_pad_model.sv
`timescale 1ns/1ps

// ==========================================================================
// board side of the pads: a released pad without pull-up wanders
module spfp_pad_model (
  input wire sys_clk,
  input wire [13:0] padOut,
  input wire [13:0] padOe,
  input wire [13:0] padPullup,
  input wire [13:0] extDrive,
  input wire [13:0] extLevel,
  output logic [13:0] padIn
);
  logic [13:0] wobble = 14'h1555;

  always @(posedge sys_clk) wobble <= ~wobble;

  always @*
    padIn = (padOe & padOut) | (~padOe & extDrive & extLevel)
      | (~padOe & ~extDrive & (padPullup | wobble));
endmodule

// >>> tb/test_shared_pin_function_priority.sv
`timescale 1ns/1ps
`include "spfp_defs.vh"

module test_shared_pin_function_priority;
  logic sys_clk = 0, arst_n = 0, pkgWide = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic timerClockEn = 0, extIrqEn = 0, extIrqPullEn = 0, extResetEn = 0, oscXtalMode = 0;
  logic oscOutReq = 0, oscOutClk = 0, oscInEn = 0;
  logic [5:0] analogChannelSel = 0, keypadEn = 0;
  logic [1:0] timerChannelEn = 0, timerChannelOe = 0, timerChannelOut = 0;
  logic [13:0] extDrive = 14'h3FFF, extLevel = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, timerChannelIn;
  wire [31:0] s_axi_rdata;
  wire timerClockIn, extIrqIn_n, extResetIn_n, oscillatorIn;
  wire [5:0] keypadIn, analogConnect;
  wire [13:0] padIn, padOut, padOe, padPullup;
  int fail_count = 0;
  int num_checks = 0;
  logic [33:0] expq[$];

  spfp_pin_mux uut (.*);
  spfp_pad_model pads (.sys_clk(sys_clk), .padOut(padOut), .padOe(padOe),
    .padPullup(padPullup), .extDrive(extDrive), .extLevel(extLevel), .padIn(padIn));

  initial forever #2 sys_clk = ~sys_clk;

  // ==========================================================================
  // compare, report and bus tasks
  task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report;
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input [5:0] idx, input [7:0] d, input [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end
    while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    s_axi_bready <= 1'b0;
    check("bresp", {32'h0, 1'b1, er}, {32'h0, s_axi_bvalid, s_axi_bresp});
  endtask

  task automatic rd(input [5:0] idx, input [31:0] d, input [1:0] er);
    int n;
    n = 0;
    expq.push_back({er, d});
    @(posedge sys_clk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    s_axi_rready <= 1'b0;
    check("rvalid", 34'h1, {33'h0, s_axi_rvalid});
  endtask

  task automatic do_reset;
    arst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check("padOe", 34'h0, padOe);
    check("padPullup", 34'h0, padPullup);
  endtask

  // read results are matched against the oldest note
  always @(posedge sys_clk)
    if (s_axi_rvalid && s_axi_rready)
      check("rdata", expq.size() ? expq.pop_front() : 34'h3FFFFFFFF, {s_axi_rresp, s_axi_rdata});

  function automatic [15:0] exp_own(input logic pa7);
    logic [1:0] o0, o1, o2, o3, o4, o5;
    o0 = timerChannelEn[0] ? 2'h2 : {1'b0, keypadEn[0]};
    o1 = timerChannelEn[1] ? 2'h2 : {1'b0, keypadEn[1]};
    o2 = extIrqEn ? 2'h3 : timerClockEn ? 2'h2 : {1'b0, keypadEn[2]};
    o3 = extResetEn ? 2'h3 : {1'b0, keypadEn[3]};
    o4 = (oscXtalMode | (oscOutReq & pa7)) ? 2'h3 : {1'b0, keypadEn[4]};
    o5 = oscInEn ? 2'h3 : {1'b0, keypadEn[5]};
    return {4'h0, o5, o4, o3, o2, o1, o0};
  endfunction

  // ==========================================================================
  // scenarios
  initial
  begin
    logic [31:0] r;
    logic [15:0] e;
    logic [5:0] kp;
    r = $urandom(76);
    // every digital function asks for its pad while reset is released
    timerChannelEn <= 2'h3;
    timerChannelOe <= 2'h3;
    keypadEn <= 6'h3F;
    {timerClockEn, extIrqEn, extResetEn, oscXtalMode, oscInEn} <= 5'h1F;
    do_reset;
    rd(`SPFP_IDX_OWNSTAT, 32'h0, `SPFP_RESP_OKAY);
    rd(6'h02, 32'h0, `SPFP_RESP_SLVERR);
    wr(6'h02, 8'hFF, `SPFP_RESP_SLVERR);
    wr(`SPFP_IDX_MUXCTL, 8'h01, `SPFP_RESP_OKAY);
    // port A stays input while analog selection runs alongside the other functions
    for (int k = 0; k < 24; k++)
    begin
      r = $urandom;
      timerChannelEn <= r[1:0];
      timerChannelOe <= r[3:2];
      timerChannelOut <= r[5:4];
      keypadEn <= r[11:6];
      {timerClockEn, extIrqEn, extIrqPullEn, extResetEn} <= r[15:12];
      {oscXtalMode, oscOutReq, oscOutClk, oscInEn} <= r[19:16];
      analogChannelSel <= r[25:20];
      extLevel <= {8'h00, r[31:26]};
      wr(`SPFP_IDX_PULLA, {r[k % 32], 7'h00}, `SPFP_RESP_OKAY);
      e = exp_own(r[k % 32]);
      rd(`SPFP_IDX_OWNSTAT, {16'h0, e}, `SPFP_RESP_OKAY);
      for (int i = 0; i < 6; i++)
        kp[i] = (e[2*i+:2] == 2'h1) & extLevel[i];
      check("keypadIn", kp, keypadIn);
      check("extIrqIn_n", (e[5:4] == 2'h3) ? extLevel[2] : 1'b1, extIrqIn_n);
      check("timerClockIn", (e[5:4] == 2'h2) & extLevel[2], timerClockIn);
      check("extResetIn_n", (e[7:6] == 2'h3) ? extLevel[3] : 1'b1, extResetIn_n);
      check("oscillatorIn", (e[11:10] == 2'h3) & extLevel[5], oscillatorIn);
      for (int i = 0; i < 2; i++)
        kp[i] = (e[2*i+:2] == 2'h2) & (timerChannelOe[i] ? timerChannelOut[i] : extLevel[i]);
      check("timerChannelIn", kp[1:0], timerChannelIn);
      if (e[1:0] == 2'h2)
        check("pad0", timerChannelOe[0] & ~timerChannelOut[0], padOe[0] & ~padOut[0]);
      if (e[7:6] == 2'h3)
        check("pad3", 2'h2, {padPullup[3], padOe[3]});
      if (e[9:8] == 2'h3)
        check("pad4", {1'b1, oscOutClk}, {padOe[4], padOut[4]});
    end
    {timerChannelEn, keypadEn, timerClockEn, extIrqEn, extResetEn} <= 11'h000;
    {oscXtalMode, oscInEn} <= 2'h0;
    analogChannelSel <= 6'h3F;
    wr(`SPFP_IDX_DIRB, 8'hFF, `SPFP_RESP_OKAY);
    wr(`SPFP_IDX_PORTB_DATA, 8'hA5, `SPFP_RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    check("analogConnect", 6'h3F, analogConnect);
    check("portB drive", 16'hFFA5, {padOe[13:6], padOut[13:6]});
    pkgWide <= 1'b0;
    do_reset;
    check("analogConnect", 6'h0F, analogConnect);
    wr(`SPFP_IDX_MUXCTL, 8'h01, `SPFP_RESP_OKAY);
    wr(`SPFP_IDX_PORTB_DATA, 8'hFF, `SPFP_RESP_OKAY);
    wr(`SPFP_IDX_DIRB, 8'hFF, `SPFP_RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    check("portB oe", 8'h00, padOe[13:6]);
    wr(`SPFP_IDX_DIRB, 8'h00, `SPFP_RESP_OKAY);
    wr(`SPFP_IDX_PULLB, 8'hFF, `SPFP_RESP_OKAY);
    rd(`SPFP_IDX_PORTB_DATA, 32'hFF, `SPFP_RESP_OKAY);
    check("portB pull", 8'h00, padPullup[13:6]);
    repeat (4) @(posedge sys_clk);
    final_report;
  end

  initial
  begin
    #40000;
    fail_count++;
    final_report;
  end
endmodule
